// File: logic/lbhcs_pkg.sv
`default_nettype none
package lbhcs_pkg;
   // bus cycle status codes on the three status lines
   localparam logic [2:0] ST_INTA  = 3'h0;
   localparam logic [2:0] ST_IORD  = 3'h1;
   localparam logic [2:0] ST_IOWR  = 3'h2;
   localparam logic [2:0] ST_HALT  = 3'h3;
   localparam logic [2:0] ST_FETCH = 3'h4;
   localparam logic [2:0] ST_MRD   = 3'h5;
   localparam logic [2:0] ST_MWR   = 3'h6;
   localparam logic [2:0] ST_PASS  = 3'h7;
   localparam int ADDR_W  = 20;
   localparam int IO_W    = 16;
   localparam int N_MID   = 4;
   localparam int N_PER   = 7;
   localparam int RESET_DRIVE_CYCLES = 1;
   typedef enum logic [2:0] {LB_IDLE, LB_T1, LB_T2, LB_T3, LB_T4, LB_HOLD} lbhcs_state_e;
endpackage
`default_nettype wire

// File: logic/lbhcs_decode.sv
`timescale 1ns/100ps
`default_nettype none
// registered address-window compare: one select per window
module lbhcs_decode #(
   parameter int N = 4,
   parameter int W = 20
) (
   input  wire logic           clock_i,
   input  wire logic           rst_b_i,
   input  wire logic           en_i,
   input  wire logic [W-1:0]   addr_i,
   input  wire logic [N*W-1:0] base_i,
   input  wire logic [N*W-1:0] limit_i,
   output logic     [N-1:0]    hit_o
);
   logic [N-1:0] next_hit;
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_win
         assign next_hit[g] = en_i && addr_i >= base_i[g*W +: W]
                           && addr_i <= limit_i[g*W +: W];
      end
   endgenerate
   // one register stage keeps the compare chain off the select pins
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         hit_o <= '0;
      end else begin
         hit_o <= next_hit;
      end
   end
endmodule
`default_nettype wire

// File: logic/lbhcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module lbhcs_top #(
   parameter int AW = lbhcs_pkg::ADDR_W
) (
   input  wire logic            clock_i,
   input  wire logic            rst_b_i,
   input  wire logic            hold_i,
   input  wire logic            cyc_req_i,
   input  wire logic [2:0]      cyc_type_i,
   input  wire logic [AW-1:0]   cyc_addr_i,
   output logic                 cyc_done_o,
   input  wire logic [AW-1:0]   upper_base_i,
   input  wire logic [AW-1:0]   lower_limit_i,
   input  wire logic [4*AW-1:0] mid_base_i,
   input  wire logic [4*AW-1:0] mid_limit_i,
   input  wire logic [7*16-1:0] per_base_i,
   input  wire logic [7*16-1:0] per_limit_i,
   input  wire logic            sel6_is_addr_i,
   input  wire logic            sel7_is_addr_i,
   output logic [2:0]           bus_cycle_status_lines_o,
   output logic                 status_oe_o,
   output logic                 bus_oe_o,
   output logic                 bus_hold_acknowledge_o,
   output logic                 bus_state_t1_o,
   output logic                 upper_memory_select_n_o,
   output logic                 lower_memory_select_n_o,
   output logic [3:0]           mid_memory_selects_n_o,
   output logic [4:0]           peripheral_selects_n_o,
   output logic                 sixth_select_or_latched_addr1_o,
   output logic                 seventh_select_or_latched_addr2_o,
   output logic                 transceiver_direction_o,
   output logic                 transceiver_enable_n_o
);
   typedef struct packed {
      lbhcs_pkg::lbhcs_state_e st;
      logic [2:0]    code;
      logic [AW-1:0] addr;
      logic          rst_seen;
      logic          status_oe;
      logic          bus_hold_acknowledge;
      logic          done;
      logic          dir;
      logic          en_n;
      logic          a1;
      logic          a2;
   } lbhcs_s;
   lbhcs_s r;
   lbhcs_s next_r;
   logic   in_cyc;
   logic   mem_hit_en;
   logic   io_hit_en;
   logic [3:0] mid_hit;
   logic [6:0] per_hit;

   function automatic logic is_io(input logic [2:0] c);
      return c == lbhcs_pkg::ST_IORD || c == lbhcs_pkg::ST_IOWR;
   endfunction
   function automatic logic is_mem(input logic [2:0] c);
      return c == lbhcs_pkg::ST_FETCH || c == lbhcs_pkg::ST_MRD || c == lbhcs_pkg::ST_MWR;
   endfunction
   function automatic logic is_write(input logic [2:0] c);
      return c == lbhcs_pkg::ST_IOWR || c == lbhcs_pkg::ST_MWR;
   endfunction

   assign in_cyc     = r.st == lbhcs_pkg::LB_T1 || r.st == lbhcs_pkg::LB_T2
                    || r.st == lbhcs_pkg::LB_T3 || r.st == lbhcs_pkg::LB_T4;
   assign mem_hit_en = in_cyc && is_mem(r.code);
   assign io_hit_en  = in_cyc && is_io(r.code);

   lbhcs_decode #(.N(4), .W(AW)) u_mid (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .en_i    (mem_hit_en),
      .addr_i  (r.addr),
      .base_i  (mid_base_i),
      .limit_i (mid_limit_i),
      .hit_o   (mid_hit)
   );
   // I/O windows compare the low 16 address bits only
   lbhcs_decode #(.N(7), .W(16)) u_per (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .en_i    (io_hit_en),
      .addr_i  (r.addr[15:0]),
      .base_i  (per_base_i),
      .limit_i (per_limit_i),
      .hit_o   (per_hit)
   );

   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      case (r.st)
         lbhcs_pkg::LB_IDLE: begin
            next_r.code = lbhcs_pkg::ST_PASS;
            if (!r.rst_seen) begin
               next_r.rst_seen  = 1'b1;
               next_r.status_oe = 1'b0;
            end else if (hold_i) begin
               next_r.st   = lbhcs_pkg::LB_HOLD;
               next_r.bus_hold_acknowledge = 1'b1;
            end else if (cyc_req_i) begin
               next_r.st        = lbhcs_pkg::LB_T1;
               next_r.status_oe = 1'b1;
               next_r.code      = cyc_type_i;
               next_r.addr      = cyc_addr_i;
               next_r.dir       = is_write(cyc_type_i);
               if (is_io(cyc_type_i) || is_mem(cyc_type_i)) begin
                  next_r.a1 = cyc_addr_i[1];
                  next_r.a2 = cyc_addr_i[2];
               end
            end
         end
         lbhcs_pkg::LB_T1: begin
            if (hold_i) begin
               // a requested hold at end of T1 preempts this cycle start
               next_r.st   = lbhcs_pkg::LB_HOLD;
               next_r.bus_hold_acknowledge = 1'b1;
               next_r.code = lbhcs_pkg::ST_PASS;
            end else begin
               next_r.st   = lbhcs_pkg::LB_T2;
               next_r.en_n = !(is_io(r.code) || is_mem(r.code));
            end
         end
         lbhcs_pkg::LB_T2: begin
            next_r.st = lbhcs_pkg::LB_T3;
         end
         lbhcs_pkg::LB_T3: begin
            next_r.st   = lbhcs_pkg::LB_T4;
            next_r.code = lbhcs_pkg::ST_PASS;
            next_r.en_n = 1'b1;
         end
         lbhcs_pkg::LB_T4: begin
            next_r.done = 1'b1;
            if (hold_i) begin
               next_r.st   = lbhcs_pkg::LB_HOLD;
               next_r.bus_hold_acknowledge = 1'b1;
            end else begin
               next_r.st = lbhcs_pkg::LB_IDLE;
            end
         end
         lbhcs_pkg::LB_HOLD: begin
            next_r.status_oe = 1'b0;
            if (!hold_i) begin
               next_r.st   = lbhcs_pkg::LB_IDLE;
               next_r.bus_hold_acknowledge = 1'b0;
            end
         end
         default: begin
            next_r.st = lbhcs_pkg::LB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         r.st        <= lbhcs_pkg::LB_IDLE;
         r.code      <= lbhcs_pkg::ST_PASS;
         r.addr      <= '0;
         r.rst_seen  <= 1'b0;
         r.status_oe <= 1'b1;
         r.bus_hold_acknowledge      <= 1'b0;
         r.done      <= 1'b0;
         r.dir       <= 1'b0;
         r.en_n      <= 1'b1;
         r.a1        <= 1'b0;
         r.a2        <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // upper and lower blocks compared combinationally on the held address
   assign upper_memory_select_n_o  = !(mem_hit_en && r.addr >= upper_base_i);
   assign lower_memory_select_n_o  = !(mem_hit_en && r.addr <= lower_limit_i);
   assign mid_memory_selects_n_o   = ~mid_hit;
   assign peripheral_selects_n_o   = ~per_hit[4:0];
   assign sixth_select_or_latched_addr1_o   = sel6_is_addr_i ? r.a1 : !per_hit[5];
   assign seventh_select_or_latched_addr2_o = sel7_is_addr_i ? r.a2 : !per_hit[6];
   assign bus_cycle_status_lines_o = r.code;
   assign status_oe_o              = r.status_oe && !r.bus_hold_acknowledge;
   assign bus_oe_o                 = !r.bus_hold_acknowledge && r.rst_seen;
   assign bus_hold_acknowledge_o   = r.bus_hold_acknowledge;
   assign bus_state_t1_o           = r.st == lbhcs_pkg::LB_T1;
   assign cyc_done_o               = r.done;
   assign transceiver_direction_o  = r.dir;
   assign transceiver_enable_n_o   = r.en_n;

   property p_hold_ack;
      @(posedge clock_i) disable iff (!rst_b_i)
      (hold_i && r.rst_seen && (r.st == lbhcs_pkg::LB_T4 || r.st == lbhcs_pkg::LB_T1))
         |=> bus_hold_acknowledge_o;
   endproperty
   a_hold_ack: assert property (p_hold_ack) else $error("hold not acknowledged");
   property p_float;
      @(posedge clock_i) disable iff (!rst_b_i)
      bus_hold_acknowledge_o |-> !bus_oe_o && !status_oe_o && transceiver_enable_n_o
         && bus_cycle_status_lines_o == lbhcs_pkg::ST_PASS;
   endproperty
   a_float: assert property (p_float) else $error("bus driven during hold");
   property p_release;
      @(posedge clock_i) disable iff (!rst_b_i)
      (r.st == lbhcs_pkg::LB_HOLD && !hold_i) |=> !bus_hold_acknowledge_o;
   endproperty
   a_release: assert property (p_release) else $error("hold ack not dropped");
   property p_rst_status;
      @(posedge clock_i) $rose(rst_b_i) |-> status_oe_o && bus_cycle_status_lines_o == 3'h7
         ##1 !status_oe_o;
   endproperty
   a_rst_status: assert property (p_rst_status) else $error("reset status drive wrong");
   property p_dir;
      @(posedge clock_i) disable iff (!rst_b_i)
      !transceiver_enable_n_o |-> transceiver_direction_o == is_write(r.code);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_en;
      @(posedge clock_i) disable iff (!rst_b_i)
      !transceiver_enable_n_o |-> r.st == lbhcs_pkg::LB_T2 || r.st == lbhcs_pkg::LB_T3;
   endproperty
   a_en: assert property (p_en) else $error("enable outside access");
   property p_dir_stable;
      @(posedge clock_i) disable iff (!rst_b_i)
      $changed(transceiver_direction_o) |-> transceiver_enable_n_o;
   endproperty
   a_dir_stable: assert property (p_dir_stable) else $error("direction moved while enabled");
   property p_latch_hold;
      @(posedge clock_i) disable iff (!rst_b_i)
      (bus_hold_acknowledge_o && $past(bus_hold_acknowledge_o)
         && sel6_is_addr_i && $past(sel6_is_addr_i)
         && sel7_is_addr_i && $past(sel7_is_addr_i))
         |-> $stable(sixth_select_or_latched_addr1_o)
            && $stable(seventh_select_or_latched_addr2_o);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched bits moved in hold");
   property p_cycle;
      @(posedge clock_i) disable iff (!rst_b_i)
      (r.st == lbhcs_pkg::LB_T2) |-> ##3 cyc_done_o;
   endproperty
   a_cycle: assert property (p_cycle) else $error("cycle did not finish");
   c_hold: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(bus_hold_acknowledge_o));
   c_write: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      !transceiver_enable_n_o && transceiver_direction_o);
   c_mid: cover property (@(posedge clock_i) disable iff (!rst_b_i) mid_memory_selects_n_o != 4'hF);
   c_hold_t4: cover property (@(posedge clock_i) disable iff (!rst_b_i)
      r.st == lbhcs_pkg::LB_T4 && hold_i);
endmodule
`default_nettype wire

// File: testbench/lbhcs_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// other bus master plus the status decode that outside logic builds
module lbhcs_far_model #(
   parameter int LAG = 1
) (
   input  wire logic       clock_i,
   input  wire logic       rst_b_i,
   input  wire logic       want_i,
   input  wire logic [2:0] status_i,
   output logic            hold_o,
   output logic            is_mem_o,
   output logic            is_wr_o
);
   logic [3:0] pipe;
   // hold changes with a lag, unrelated to the device's bus state
   always_ff @(posedge clock_i) begin
      pipe <= rst_b_i ? {pipe[2:0], want_i} : 4'h0;
   end
   assign hold_o   = pipe[LAG-1];
   assign is_mem_o = status_i[2];
   assign is_wr_o  = status_i[1];
endmodule
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk = 1'b0, rst_b = 1'b0, want = 1'b0, req = 1'b0, m6 = 1'b0, m7 = 1'b0;
   logic hold, done, s_oe, b_oe, ack, t1, upper_memory_select_n, lower_memory_select_n, p6, p7, dir, en_n, is_mem, is_wr;
   logic [2:0]  ctype = 3'h0;
   logic [2:0]  st;
   logic [19:0] caddr = 20'h00000;
   logic [3:0]  mid;
   logic [4:0]  per;
   logic [79:0] mb, ml;
   logic [111:0] pb, pl;
   int mismatches = 0, checks = 0;
   always #2.5 clk = ~clk;
   for (genvar g = 0; g < 4; g++) begin : g_mid
      assign mb[g*20+:20] = 20'h20000 + 20'(g) * 20'h10000;
      assign ml[g*20+:20] = 20'h2FFFF + 20'(g) * 20'h10000;
   end
   for (genvar k = 0; k < 7; k++) begin : g_per
      assign pb[k*16+:16] = 16'(k) * 16'h0100;
      assign pl[k*16+:16] = 16'(k) * 16'h0100 + 16'h00FF;
   end
   lbhcs_far_model u_lbhcs_far_model (.clock_i(clk), .rst_b_i(rst_b), .want_i(want),
      .status_i(st), .hold_o(hold), .is_mem_o(is_mem), .is_wr_o(is_wr));
   lbhcs_top u_lbhcs_top (.clock_i(clk), .rst_b_i(rst_b), .hold_i(hold), .cyc_req_i(req),
      .cyc_type_i(ctype), .cyc_addr_i(caddr), .cyc_done_o(done), .upper_base_i(20'hC0000),
      .lower_limit_i(20'h0FFFF), .mid_base_i(mb), .mid_limit_i(ml), .per_base_i(pb),
      .per_limit_i(pl), .sel6_is_addr_i(m6), .sel7_is_addr_i(m7),
      .bus_cycle_status_lines_o(st), .status_oe_o(s_oe), .bus_oe_o(b_oe),
      .bus_hold_acknowledge_o(ack), .bus_state_t1_o(t1), .upper_memory_select_n_o(upper_memory_select_n),
      .lower_memory_select_n_o(lower_memory_select_n), .mid_memory_selects_n_o(mid),
      .peripheral_selects_n_o(per), .sixth_select_or_latched_addr1_o(p6),
      .seventh_select_or_latched_addr2_o(p7), .transceiver_direction_o(dir),
      .transceiver_enable_n_o(en_n));
   task automatic cmp(input logic [19:0] seen, input logic [19:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ex packs {upper, lower, mid[3:0], per[4:0], sixth, seventh} at T2
   task automatic run_cycle(input logic [2:0] t, input logic [19:0] a, input logic [12:0] ex);
      int n;
      logic w;
      logic m;
      ctype = t;
      caddr = a;
      req = 1'b1;
      n = 0;
      w = (t == lbhcs_pkg::ST_IOWR) || (t == lbhcs_pkg::ST_MWR);
      m = t inside {lbhcs_pkg::ST_FETCH, lbhcs_pkg::ST_MRD, lbhcs_pkg::ST_MWR};
      do begin tick(1); n++; end while (t1 !== 1'b1 && n < 8);
      req = 1'b0;
      cmp(t1, 1'b1, "cycle in T1");
      cmp(st, t, "status code");
      cmp(s_oe, 1'b1, "status driven in T1");
      cmp(dir, w, "direction");
      // halt leaves the middle line high although no data moves
      cmp(is_wr, w || t == lbhcs_pkg::ST_HALT, "decoded direction");
      cmp(is_mem, m, "decoded memory");
      tick(1);
      if (t inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6}) cmp(en_n, 1'b0, "enable in access");
      else cmp(en_n, 1'b1, "enable outside access");
      cmp({upper_memory_select_n, lower_memory_select_n, mid, per, p6, p7}, ex, "selects");
      n = 0;
      while (done !== 1'b1 && n < 8) begin tick(1); n++; end
      cmp(done, 1'b1, "cycle done");
      cmp(en_n, 1'b1, "enable after access");
      tick(1);
   endtask
   task automatic t_reset;
      tick(8);
      cmp(st, lbhcs_pkg::ST_PASS, "status in reset");
      cmp(s_oe, 1'b1, "status driven in reset");
      cmp(b_oe, 1'b0, "bus idle in reset");
      cmp(ack, 1'b0, "no hold ack in reset");
      cmp(en_n, 1'b1, "enable high in reset");
      rst_b = 1'b1;
      // status stays driven up to the first edge after release
      cmp(s_oe, 1'b1, "status one clock");
      tick(1);
      cmp(s_oe, 1'b0, "status floated");
      cmp(st, lbhcs_pkg::ST_PASS, "status passive after reset");
      tick(1);
      cmp(s_oe, 1'b0, "status stays floated");
      cmp(b_oe, 1'b1, "bus driven after reset");
      $display("test reset done");
   endtask
   task automatic t_codes;
      for (int c = 0; c < 7; c++) run_cycle(3'(c), 20'h8F000, 13'h1FFF);
      $display("test codes done");
   endtask
   task automatic t_selects;
      run_cycle(lbhcs_pkg::ST_MRD, 20'hC0010, 13'h0FFF);
      run_cycle(lbhcs_pkg::ST_MWR, 20'h00100, 13'h17FF);
      run_cycle(lbhcs_pkg::ST_MRD, 20'h31000, 13'h1EFF);
      run_cycle(lbhcs_pkg::ST_IOWR, 20'h00203, 13'h1FEF);
      run_cycle(lbhcs_pkg::ST_IORD, 20'h00606, 13'h1FFE);
      $display("test selects done");
   endtask
   task automatic t_hold;
      int n;
      m6 = 1'b1;
      m7 = 1'b1;
      run_cycle(lbhcs_pkg::ST_IORD, 20'h8F002, 13'h1FFE);
      want = 1'b1;
      n = 0;
      while (ack !== 1'b1 && n < 6) begin tick(1); n++; end
      cmp(ack, 1'b1, "hold acknowledge");
      cmp(b_oe, 1'b0, "bus floated");
      cmp(s_oe, 1'b0, "status floated in hold");
      // a request in hold must neither start nor relatch the address bits
      ctype = lbhcs_pkg::ST_IORD;
      caddr = 20'h00004;
      req = 1'b1;
      tick(4);
      cmp(t1, 1'b0, "no cycle in hold");
      cmp({p6, p7}, 2'b10, "latched bits in hold");
      req = 1'b0;
      want = 1'b0;
      n = 0;
      while (ack !== 1'b0 && n < 6) begin tick(1); n++; end
      cmp(ack, 1'b0, "acknowledge dropped");
      cmp(b_oe, 1'b1, "bus retaken");
      m6 = 1'b0;
      m7 = 1'b0;
      run_cycle(lbhcs_pkg::ST_MRD, 20'hC0010, 13'h0FFF);
      $display("test hold done");
   endtask
   task automatic t_hold_edges;
      // hold seen at the end of T1 drops the cycle before any access
      ctype = lbhcs_pkg::ST_MRD;
      caddr = 20'h00100;
      req = 1'b1;
      want = 1'b1;
      tick(1);
      req = 1'b0;
      cmp(t1, 1'b1, "cycle started");
      tick(1);
      cmp(ack, 1'b1, "hold at end of T1");
      cmp(en_n, 1'b1, "no access after T1 hold");
      want = 1'b0;
      tick(3);
      cmp(ack, 1'b0, "release after T1 hold");
      cmp(done, 1'b0, "dropped cycle not finished");
      // hold seen at the end of T4 lets the cycle finish first
      req = 1'b1;
      tick(1);
      req = 1'b0;
      cmp(t1, 1'b1, "second cycle started");
      tick(2);
      want = 1'b1;
      tick(2);
      cmp(done, 1'b1, "cycle finished before hold");
      cmp(ack, 1'b1, "hold at end of T4");
      cmp(b_oe, 1'b0, "bus floated after T4");
      want = 1'b0;
      tick(3);
      cmp(ack, 1'b0, "release after T4 hold");
      $display("test hold edges done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      t_reset();
      t_codes();
      t_selects();
      t_hold();
      t_hold_edges();
      final_report();
   end
   // tests need some 115 cycles; give over seventeen times that
   initial begin
      #10000;
      mismatches++;
      final_report();
   end
endmodule
`default_nettype wire
